//--- rtl/cam_valid_defs.svh
// constants for the validity and initialisation decoder
// assumes: included by the package and the decoder module
`ifndef CAM_VALID_DEFS_SVH
`define CAM_VALID_DEFS_SVH
`define CV_DEPTH        8192
`define CV_AW           13
`define CV_MASKS        7
// low six bits of the control state
`define OP_MARK_VALID   6'h20
`define OP_MARK_EMPTY   6'h21
`define OP_EMPTY_TOP    6'h22
`define OP_EMPTY_ALL    6'h23
`define OP_STEP_UP      6'h24
`define OP_STEP_DOWN    6'h25
`define OP_LOAD_TIER    6'h3c
`define OP_CLEAR_FULL   6'h3d
`define OP_SOFT_RESET   6'h3f
// configuration fields
`define CFG_WMASK_HI    31
`define CFG_WMASK_LO    29
`define CFG_MODE_HI     27
`define CFG_MODE_LO     26
`define CFG_LPC         25
`define CFG_PAGE_HI     3
`define CFG_PAGE_LO     0
`define CFG_WMASK_ZERO  3'h0
`define MODE_HW         2'h0
`define MODE_SW         2'h3
`define CFG_RESET       32'h0e00000f
`define CFG_WR_MASK     32'hee00000f
// device select fields
`define DSEL_SELECT_ENABLE_N      8
`define DSEL_RESET      32'h0000010f
`define DSEL_WR_MASK    32'h0000010f
// status fields
`define SR_MF           30
`define SR_MM           29
`define SR_FF           28
`define SR_TYPE_HI      25
`define SR_TYPE_LO      24
`define SR_PAGE_HI      19
`define SR_PAGE_LO      16
`define TYPE_MATCH      2'h0
`define TYPE_MEMORY     2'h1
`define TYPE_RESET      2'h3
// register port indices
`define RA_CFG          5'h00
`define RA_DSEL         5'h01
`define RA_CMP_LO       5'h02
`define RA_CMP_HI       5'h03
`define RA_MASK_BASE    5'h04
`define RA_MASK_LAST    5'h11
`endif

//--- rtl/cam_valid_pkg.sv
// types shared by the decoder and its surroundings
// assumes: cam_valid_defs.svh on the include path
`include "cam_valid_defs.svh"
package cam_valid_pkg;
    typedef struct packed {
        logic        strobe;
        logic        write_n;
        logic        address_valid_n;
        logic        word_half_select;
        logic [5:0]  op;
        logic [31:0] dq;
    } ctl_cmd_t;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [31:0] data;
    } reg_req_t;
    typedef struct packed {
        logic             found;
        logic [`CV_AW-1:0] idx;
    } pick_t;
endpackage

//--- rtl/cam_valid_ctrl.sv
// validity, initialisation and pointer control of the lookup array
// assumes: one synchronous controller, comparisons done outside
`timescale 1ns/1ps
`default_nettype none
`include "cam_valid_defs.svh"

// Operation
// - mark-valid write clears addressed validity bit
// - validity read returns bit on dq0
// - mark-empty sets addressed validity bit
// - empty top match, drive its index
// - empty every retained matching entry
// - first non-full device loads page, goes full
// - clear-full returns full flag high
// - soft reset drives all-ones page/index
// - step-up adds one to pointer
// - step-down subtracts one from pointer
// - resets empty array, clear pointer, masks
// - hardware reset loads config; soft keeps
// - status after reset: no match, not full
// - config 31:29 selects direct write mask
// - config 27:26 control mode; status access
// - config bit 25 low flags low priority
// - compares only consider valid entries
// - next-free lands where chain low, not full
module cam_valid_ctrl (
    input  wire logic                     mclk,
    input  wire logic                     resetn,
    input  wire cam_valid_pkg::ctl_cmd_t  cmd,
    input  wire cam_valid_pkg::reg_req_t  reg_req,
    input  wire logic                     full_chain_in_n,
    input  wire logic                     cmp_done,
    input  wire logic [`CV_DEPTH-1:0]     cmp_hits,
    output logic [31:0]                   dq_out,
    output logic                          dq_oe_n,
    output logic                          full_flag_n,
    output logic [3:0]                    device_tier_code,
    output logic [`CV_AW-1:0]             active_index,
    output logic [1:0]                    active_type,
    output logic                          low_priority_array,
    output logic                          select_enable_n,
    output logic                          sw_control,
    output logic [63:0]                   write_mask,
    output logic [63:0]                   comparand,
    output logic                          nf_target,
    output logic [`CV_AW-1:0]             next_empty_slot
);
    import cam_valid_pkg::*;

    logic [`CV_DEPTH-1:0] empty;
    logic [`CV_DEPTH-1:0] hits;
    logic [`CV_AW-1:0]    addr;
    logic [31:0]          cfg;
    logic [31:0]          dsel;
    logic [63:0]          mask_reg [1:`CV_MASKS];
    logic                 go;
    logic                 wr;
    logic                 sreset;
    logic                 tier_here;
    pick_t                top;
    pick_t                free;
    logic                 multi;
    logic [31:0]          status;
    logic [2:0]           mask_idx;

    // lowest index has the highest priority
    function automatic pick_t first_one(input logic [`CV_DEPTH-1:0] v);
        pick_t p;
        p = '0;
        for (int i = `CV_DEPTH - 1; i >= 0; i--) begin
            if (v[i]) begin
                p.found = 1'b1;
                p.idx   = i[`CV_AW-1:0];
            end
        end
        return p;
    endfunction

    function automatic logic hit(input logic [5:0] code);
        return go && cmd.op == code;
    endfunction

    assign go        = cmd.strobe && cmd.address_valid_n;
    assign wr        = !cmd.write_n;
    assign sreset    = hit(`OP_SOFT_RESET) && wr;
    assign tier_here = !full_chain_in_n && full_flag_n;
    assign top       = first_one(hits);
    assign free      = first_one(empty);
    assign multi     = |(hits & (hits - `CV_DEPTH'(1)));
    assign mask_idx  = 3'((reg_req.addr - `RA_MASK_BASE) >> 1);

    always_comb begin
        status = '0;
        status[`SR_MF] = !top.found;
        status[`SR_MM] = !multi;
        status[`SR_FF] = full_flag_n;
        status[`SR_TYPE_HI:`SR_TYPE_LO] = active_type;
        status[`SR_PAGE_HI:`SR_PAGE_LO] = device_tier_code;
        status[`CV_AW-1:0] = active_index;
    end

    // validity bits, 1 = empty
    always_ff @(posedge mclk) begin
        if (!resetn || sreset) begin
            empty <= '1;
        end else if (hit(`OP_MARK_VALID) && wr) begin
            empty[addr] <= 1'b0;
        end else if (hit(`OP_MARK_EMPTY) && wr) begin
            empty[addr] <= 1'b1;
        end else if (hit(`OP_EMPTY_TOP) && wr && top.found) begin
            empty[top.idx] <= 1'b1;
        end else if (hit(`OP_EMPTY_ALL) && wr) begin
            empty <= empty | hits;
        end
    end

    // retained match set
    always_ff @(posedge mclk) begin
        if (!resetn || sreset) begin
            hits <= '0;
        end else if (cmp_done) begin
            hits <= cmp_hits & ~empty;
        end
    end

    // address pointer
    always_ff @(posedge mclk) begin
        if (!resetn || sreset) begin
            addr <= '0;
        end else if (hit(`OP_STEP_UP) && wr) begin
            addr <= addr + `CV_AW'(1);
        end else if (hit(`OP_STEP_DOWN) && wr) begin
            addr <= addr - `CV_AW'(1);
        end
    end

    // configuration, untouched by soft reset
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cfg <= `CFG_RESET;
        end else if (hit(`OP_LOAD_TIER) && wr && tier_here) begin
            cfg[`CFG_PAGE_HI:`CFG_PAGE_LO] <= cmd.dq[3:0];
        end else if (reg_req.wr && reg_req.addr == `RA_CFG) begin
            cfg <= reg_req.data & `CFG_WR_MASK;
        end
    end

    // device select
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            dsel <= `DSEL_RESET;
        end else if (sreset) begin
            dsel[`DSEL_SELECT_ENABLE_N] <= 1'b1;
        end else if (reg_req.wr && reg_req.addr == `RA_DSEL) begin
            dsel <= reg_req.data & `DSEL_WR_MASK;
        end
    end

    // comparand and mask registers
    always_ff @(posedge mclk) begin
        if (!resetn || sreset) begin
            comparand <= '0;
            for (int k = 1; k <= `CV_MASKS; k++) begin
                mask_reg[k] <= '0;
            end
        end else if (reg_req.wr) begin
            if (reg_req.addr == `RA_CMP_LO) begin
                comparand[31:0] <= reg_req.data;
            end else if (reg_req.addr == `RA_CMP_HI) begin
                comparand[63:32] <= reg_req.data;
            end else if (reg_req.addr >= `RA_MASK_BASE &&
                         reg_req.addr <= `RA_MASK_LAST) begin
                if (reg_req.addr[0]) begin
                    mask_reg[mask_idx + 3'h1][63:32] <= reg_req.data;
                end else begin
                    mask_reg[mask_idx + 3'h1][31:0] <= reg_req.data;
                end
            end
        end
    end

    // full flag of the cascade chain
    always_ff @(posedge mclk) begin
        if (!resetn || sreset) begin
            full_flag_n <= 1'b1;
        end else if (hit(`OP_LOAD_TIER) && wr && tier_here) begin
            full_flag_n <= 1'b0;
        end else if (hit(`OP_CLEAR_FULL) && wr) begin
            full_flag_n <= 1'b1;
        end
    end

    // page and active index outputs
    always_ff @(posedge mclk) begin
        if (!resetn || sreset) begin
            device_tier_code <= 4'hf;
            active_index     <= '1;
            active_type      <= `TYPE_RESET;
        end else if (go && wr && (cmd.op == `OP_MARK_VALID ||
                                  cmd.op == `OP_MARK_EMPTY)) begin
            device_tier_code <= cfg[`CFG_PAGE_HI:`CFG_PAGE_LO];
            active_index     <= addr;
            active_type      <= `TYPE_MEMORY;
        end else if (go && !wr && cmd.op == `OP_MARK_VALID) begin
            device_tier_code <= cfg[`CFG_PAGE_HI:`CFG_PAGE_LO];
            active_index     <= addr;
            active_type      <= `TYPE_MEMORY;
        end else if (go && wr && (cmd.op == `OP_EMPTY_TOP ||
                                  cmd.op == `OP_EMPTY_ALL)) begin
            device_tier_code <= cfg[`CFG_PAGE_HI:`CFG_PAGE_LO];
            active_index     <= top.idx;
            active_type      <= `TYPE_MATCH;
        end
    end

    // data bus answers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            dq_out  <= '0;
            dq_oe_n <= 1'b1;
        end else if (hit(`OP_MARK_VALID) && !wr) begin
            dq_out  <= {31'h0, empty[addr]};
            dq_oe_n <= 1'b0;
        end else if (reg_req.rd) begin
            dq_oe_n <= 1'b0;
            if (sw_control && cmd.address_valid_n) begin
                dq_out <= status;
            end else if (reg_req.addr == `RA_CFG) begin
                dq_out <= cfg;
            end else if (reg_req.addr == `RA_DSEL) begin
                dq_out <= dsel;
            end else begin
                dq_out <= status;
            end
        end else begin
            dq_out  <= '0;
            dq_oe_n <= 1'b1;
        end
    end

    // configuration fields, next-free target and next empty slot brought out
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            write_mask         <= '0;
            low_priority_array <= 1'b0;
            select_enable_n    <= 1'b1;
            sw_control         <= 1'b1;
            nf_target          <= 1'b0;
            next_empty_slot    <= '0;
        end else begin
            if (cfg[`CFG_WMASK_HI:`CFG_WMASK_LO] == `CFG_WMASK_ZERO) begin
                write_mask <= '0;
            end else begin
                write_mask <= mask_reg[cfg[`CFG_WMASK_HI:`CFG_WMASK_LO]];
            end
            low_priority_array <= !cfg[`CFG_LPC];
            select_enable_n    <= dsel[`DSEL_SELECT_ENABLE_N];
            sw_control <= cfg[`CFG_MODE_HI:`CFG_MODE_LO] == `MODE_SW;
            nf_target          <= tier_here;
            next_empty_slot    <= free.idx;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_cmd(logic [5:0] code);
        go && wr && cmd.op == code;
    endsequence
    sequence s_tier_load;
        s_cmd(`OP_LOAD_TIER) ##0 tier_here;
    endsequence

    a_mark_valid: assert property (s_cmd(`OP_MARK_VALID) |=> !empty[$past(addr)])
        else $error("mark valid failed");
    a_valid_read: assert property (go && !wr && cmd.op == `OP_MARK_VALID
        |=> !dq_oe_n && dq_out == {31'h0, $past(empty[addr])})
        else $error("validity read wrong");
    a_mark_empty: assert property (s_cmd(`OP_MARK_EMPTY) |=> empty[$past(addr)])
        else $error("mark empty failed");
    a_top_clear: assert property (s_cmd(`OP_EMPTY_TOP) ##0 top.found
        |=> empty[$past(top.idx)] && active_index == $past(top.idx))
        else $error("top match not cleared");
    a_all_clear: assert property (s_cmd(`OP_EMPTY_ALL)
        |=> (empty & $past(hits)) == $past(hits))
        else $error("matches not cleared");
    a_tier_load: assert property (s_tier_load
        |=> cfg[`CFG_PAGE_HI:`CFG_PAGE_LO] == $past(cmd.dq[3:0]) && !full_flag_n)
        else $error("page load failed");
    a_tier_skip: assert property (s_cmd(`OP_LOAD_TIER) ##0 !tier_here
        |=> $stable(cfg) && $stable(full_flag_n))
        else $error("page loaded out of turn");
    a_full_clear: assert property (s_cmd(`OP_CLEAR_FULL) |=> full_flag_n)
        else $error("full flag not cleared");
    a_soft_reset: assert property (s_cmd(`OP_SOFT_RESET) |=> active_index == '1
        && device_tier_code == 4'hf && addr == '0 && dsel[`DSEL_SELECT_ENABLE_N]
        && $stable(cfg) ##1 select_enable_n)
        else $error("soft reset incomplete");
    a_step_up: assert property (s_cmd(`OP_STEP_UP)
        |=> addr == $past(addr) + `CV_AW'(1))
        else $error("pointer step up wrong");
    a_step_down: assert property (s_cmd(`OP_STEP_DOWN)
        |=> addr == $past(addr) - `CV_AW'(1))
        else $error("pointer step down wrong");
    a_mask_none: assert property (cfg[31:29] == 3'h0 |=> write_mask == '0)
        else $error("mask applied when none chosen");
    a_hits_kept: assert property (!cmp_done && !sreset |=> $stable(hits))
        else $error("match set lost");
    a_hits_valid: assert property (cmp_done |=> (hits & $past(empty)) == '0)
        else $error("empty entry matched");
endmodule // cam_valid_ctrl
`default_nettype wire

//--- bench/cam_ctl_partner.sv
// controller model: drives control states and register requests
// assumes: decoder samples both ports on rising mclk
`timescale 1ns/1ps
`default_nettype none
module cam_ctl_partner (
    input  wire logic                   mclk,
    output var cam_valid_pkg::ctl_cmd_t cmd,
    output var cam_valid_pkg::reg_req_t reg_req
);
    import cam_valid_pkg::*;
    initial begin
        cmd = '0;
        reg_req = '0;
    end
    // documented opcodes only, half select held low
    task automatic issue(input logic [5:0] op, input logic wn, input logic [31:0] d);
        @(posedge mclk) #2;
        cmd <= '{1'b1, wn, 1'b1, 1'b0, op, d};
        @(posedge mclk) #2;
        cmd <= '{1'b0, 1'b1, 1'b0, 1'b0, ~op, ~d};
    endtask
    // av high in software mode steers the read to status
    task automatic rw(input logic wr, input logic av, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk) #2;
        reg_req             <= '{wr, ~wr, a, d};
        cmd.address_valid_n <= av;
        @(posedge mclk) #2;
        reg_req             <= '{1'b0, 1'b0, ~a, ~d};
        cmd.address_valid_n <= 1'b0;
    endtask
endmodule // cam_ctl_partner
`default_nettype wire

//--- bench/cam_valid_ctrl_bench.sv
// self-checking bench of the validity and initialisation decoder
// assumes: partner model drives the control and register ports
`timescale 1ns/1ps
`default_nettype none
`include "cam_valid_defs.svh"
`define CHK(a, e) begin \
    n_checks++; \
    if ((a) !== (e)) begin \
        num_errors++; \
        $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); \
    end \
end
module cam_valid_ctrl_bench;
    import cam_valid_pkg::*;
    logic                 mclk = 1'b0;
    logic                 resetn = 1'b0;
    logic                 full_chain_in_n = 1'b1;
    logic                 cmp_done = 1'b0;
    logic [`CV_DEPTH-1:0] cmp_hits = '0;
    ctl_cmd_t             cmd;
    reg_req_t             reg_req;
    logic [31:0]          dq_out, cfgv, d, ds;
    logic                 dq_oe_n, full_flag_n, low_priority_array, select_enable_n, sw_control, nf_target;
    logic [3:0]           device_tier_code;
    logic [`CV_AW-1:0]    active_index, next_empty_slot, ptr;
    logic [1:0]           active_type;
    logic [63:0]          write_mask, comparand;
    logic [63:0]          m [0:7];
    int                   num_errors = 0;
    int                   n_checks = 0;

    always #10 mclk = ~mclk;

    cam_ctl_partner u_partner (.mclk(mclk), .cmd(cmd), .reg_req(reg_req));
    cam_valid_ctrl u_dut (
        .mclk(mclk), .resetn(resetn), .cmd(cmd), .reg_req(reg_req),
        .full_chain_in_n(full_chain_in_n), .cmp_done(cmp_done), .cmp_hits(cmp_hits),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .full_flag_n(full_flag_n),
        .device_tier_code(device_tier_code), .active_index(active_index),
        .active_type(active_type), .low_priority_array(low_priority_array),
        .select_enable_n(select_enable_n), .sw_control(sw_control),
        .write_mask(write_mask), .comparand(comparand), .nf_target(nf_target),
        .next_empty_slot(next_empty_slot)
    );

    task automatic op(input logic [5:0] c, input logic wn);
        u_partner.issue(c, wn, $urandom);
    endtask
    task automatic goto(input logic [`CV_AW-1:0] t);
        while (ptr != t) begin
            if (ptr < t) begin
                op(`OP_STEP_UP, 1'b0);
                ptr++;
            end else begin
                op(`OP_STEP_DOWN, 1'b0);
                ptr--;
            end
        end
    endtask
    task automatic rdv(input logic e);
        op(`OP_MARK_VALID, 1'b1);
        `CHK(dq_out, {31'h0, e})
        `CHK(dq_oe_n, 1'b0)
        `CHK(active_index, ptr)
    endtask
    task automatic rreg(input logic av, input logic [4:0] a, input logic [31:0] e);
        u_partner.rw(1'b0, av, a, 32'h0);
        `CHK(dq_out, e)
        `CHK(dq_oe_n, 1'b0)
    endtask
    task automatic wreg(input logic [4:0] a, input logic [31:0] v);
        u_partner.rw(1'b1, 1'b0, a, v);
        @(posedge mclk) #2;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h1e43b6a6));
        ptr = '0;
        m[0] = '0;
        repeat (20) @(posedge mclk);
        #2 resetn = 1'b1;
        `CHK({full_flag_n, device_tier_code, active_index, active_type}, 20'hfffff)
        `CHK({select_enable_n, sw_control, low_priority_array}, 3'h6)
        `CHK({write_mask, comparand}, 128'h0)
        `CHK(next_empty_slot, 13'h0)
        rreg(1'b0, 5'h1f, 32'h730f1fff);
        rreg(1'b0, `RA_CFG, 32'h0e00000f);
        rreg(1'b0, `RA_DSEL, 32'h0000010f);
        rreg(1'b1, `RA_DSEL, 32'h730f1fff);
        $display("done: reset values");
        ds = $urandom;
        wreg(`RA_DSEL, ds);
        `CHK(select_enable_n, ds[8])
        rreg(1'b0, `RA_DSEL, ds & 32'h10f);
        for (int i = 1; i < 8; i++) begin
            m[i] = {$urandom, $urandom};
            wreg(5'(2 * i + 2), m[i][31:0]);
            wreg(5'(2 * i + 3), m[i][63:32]);
        end
        for (int k = 0; k < 8; k++) begin
            d = $urandom;
            cfgv = {3'(k), 1'b0, {2{d[0]}}, d[1], 21'h0, d[5:2]};
            wreg(`RA_CFG, cfgv);
            `CHK(write_mask, m[k])
            `CHK(sw_control, cfgv[26])
            `CHK(low_priority_array, ~cfgv[25])
            rreg(1'b1, `RA_CFG, cfgv[26] ? 32'h730f1fff : cfgv);
        end
        d = $urandom;
        wreg(`RA_CMP_LO, d);
        wreg(`RA_CMP_HI, ~d);
        `CHK(comparand, {~d, d})
        $display("done: registers");
        rdv(1'b1);
        op(`OP_MARK_VALID, 1'b0);
        rdv(1'b0);
        `CHK(next_empty_slot, 13'h1)
        op(`OP_MARK_EMPTY, 1'b0);
        rdv(1'b1);
        goto(13'(1 + $urandom_range(20)));
        op(`OP_MARK_VALID, 1'b0);
        goto(13'(ptr - 1));
        rdv(1'b1);
        goto(13'(ptr + 1));
        rdv(1'b0);
        $display("done: validity");
        for (int i = 1; i < 4; i++) begin
            goto(13'(i));
            op(`OP_MARK_VALID, 1'b0);
        end
        @(posedge mclk) #2;
        cmp_hits[2:0] = 3'h7;
        cmp_done = 1'b1;
        @(posedge mclk) #2;
        cmp_done = 1'b0;
        cmp_hits = '1;
        op(`OP_EMPTY_TOP, 1'b0);
        `CHK(active_index, 13'h1)
        goto(13'h1);
        rdv(1'b1);
        goto(13'h2);
        rdv(1'b0);
        op(`OP_EMPTY_ALL, 1'b0);
        rdv(1'b1);
        goto(13'h3);
        rdv(1'b0);
        $display("done: compare");
        u_partner.issue(`OP_LOAD_TIER, 1'b0, 32'h5);
        `CHK(full_flag_n, 1'b1)
        full_chain_in_n = 1'b0;
        d = $urandom;
        u_partner.issue(`OP_LOAD_TIER, 1'b0, d);
        `CHK(full_flag_n, 1'b0)
        cfgv[3:0] = d[3:0];
        u_partner.issue(`OP_LOAD_TIER, 1'b0, ~d);
        rreg(1'b0, `RA_CFG, cfgv);
        `CHK(nf_target, 1'b0)
        op(`OP_CLEAR_FULL, 1'b0);
        `CHK(full_flag_n, 1'b1)
        @(posedge mclk) #2;
        `CHK(nf_target, 1'b1)
        $display("done: tier load");
        op(`OP_SOFT_RESET, 1'b0);
        ptr = '0;
        `CHK({full_flag_n, device_tier_code, active_index, active_type}, 20'hfffff)
        `CHK(comparand, 64'h0)
        // mask select and select enable follow their registers one edge later
        @(posedge mclk) #2;
        `CHK(write_mask, 64'h0)
        `CHK(select_enable_n, 1'b1)
        rreg(1'b0, `RA_CFG, cfgv);
        rreg(1'b0, `RA_DSEL, {23'h0, 1'b1, 4'h0, ds[3:0]});
        goto(13'h3);
        rdv(1'b1);
        $display("done: soft reset");
        final_report;
    end

    initial begin
        #200000;
        num_errors++;
        final_report;
    end
endmodule // cam_valid_ctrl_bench
`default_nettype wire
